// [aelr_defines.vh]
// Constants for the advanced error log register bank
`ifndef AELR_DEFINES_VH
`define AELR_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define AELR_ADDR_ADV_CTRL   12'h118
`define AELR_ADDR_HDR_LOG0   12'h11C
`define AELR_ADDR_HDR_LOG1   12'h120
`define AELR_ADDR_HDR_LOG2   12'h124
`define AELR_ADDR_HDR_LOG3   12'h128
`define AELR_ADDR_SEC_STS    12'h12C

// ****************************************************************
// Field positions
// ****************************************************************
`define AELR_CRC_CHK_EN_BIT  8
`define AELR_CRC_CHK_CAP_BIT 7
`define AELR_CRC_GEN_EN_BIT  6
`define AELR_CRC_GEN_CAP_BIT 5
`define AELR_FEI_MSB         4
`define AELR_FEI_LSB         0
`define AELR_SEC_IBF_BIT     13
`define AELR_SEC_SERR_BIT    12
`define AELR_SEC_STS_IMPL    16'h3FEF

// ****************************************************************
// Reset values
// ****************************************************************
`define AELR_ADV_CTRL_RST    32'h00000000
`define AELR_FEI_RST         5'h00
`define AELR_HDR_WORD_RST    32'h00000000
`define AELR_SEC_STS_RST     16'h0000

// ****************************************************************
// Decode codes and bus responses
// ****************************************************************
`define AELR_DEC_NONE        3'h0
`define AELR_DEC_CTRL        3'h1
`define AELR_DEC_HDR         3'h2
`define AELR_DEC_SEC         3'h3
`define AELR_RESP_OKAY       2'h0
`define AELR_RESP_SLVERR     2'h2

`endif

// [aelr_hdr_mem.v]
// Four-word sticky store for the captured transaction header
`timescale 1ns/1ps
`include "aelr_defines.vh"

module aelr_hdr_mem #(
  parameter WORD_W = 32,
  parameter WORDS  = 4,
  parameter IDX_W  = 2
) (
  input  wire                      clock_i,
  input  wire                      rst_n_i,
  input  wire                      ce_i,
  input  wire                      wr_en_i,
  input  wire [WORD_W*WORDS-1:0]   wr_data_i,
  input  wire                      rd_en_i,
  input  wire [IDX_W-1:0]          rd_idx_i,
  output wire [WORD_W-1:0]         rd_data_o
);

  reg [WORD_W*WORDS-1:0] store_reg;
  reg [WORD_W-1:0]       rd_data_reg;

  // Only power-good clears the stored header
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      store_reg   <= {(WORD_W*WORDS){1'b0}};
      rd_data_reg <= `AELR_HDR_WORD_RST;
    end else if (ce_i) begin
      if (wr_en_i) begin
        store_reg <= wr_data_i;
      end
      if (rd_en_i) begin
        rd_data_reg <= store_reg[rd_idx_i*WORD_W +: WORD_W];
      end
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule // aelr_hdr_mem

// [aelr_top.v]
// Advanced error control, header log and secondary status registers
//
// Summary of operation
// - The CRC check enable bit reads zero and acts as reserved.
// - The CRC check capable bit always reads zero.
// - The CRC generation enable bit reads zero and writes do nothing.
// - The CRC generation capable bit always reads zero.
// - A sticky 5-bit field holds the index of the first error seen.
// - Clearing the status bit it points at re-arms it, value kept.
// - A transaction error captures the full 128-bit header, sticky.
// - After a capture the log is locked until its status is cleared.
// - Secondary status bits set on events and clear on write of one.
// - The internal bridge fault bit sets on queue data errors.
// - The system error seen bit sets while the error pin is low.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "aelr_defines.vh"

module aelr_top #(
  parameter ADDR_W = 12,
  parameter HDR_W  = 128
) (
  input  wire              clock_i,
  input  wire              rst_n_i,
  input  wire              ce_i,
  input  wire              link_rst_i,
  input  wire              unc_err_valid_i,
  input  wire [4:0]        unc_err_index_i,
  input  wire [31:0]       unc_sts_clear_i,
  input  wire              tlp_err_valid_i,
  input  wire [HDR_W-1:0]  tlp_hdr_i,
  input  wire              hdr_sts_clear_i,
  input  wire              internal_bridge_fault_i,
  input  wire              secondary_system_error_pin_n_i,
  input  wire [15:0]       sec_err_event_i,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  output wire [4:0]        first_error_index_o,
  output wire              hdr_log_locked_o
);

  // ****************************************************************
  // State encodings
  // ****************************************************************
  localparam [1:0] WS_IDLE = 2'b01;
  localparam [1:0] WS_RESP = 2'b10;
  localparam [2:0] RS_IDLE = 3'b001;
  localparam [2:0] RS_DATA = 3'b010;
  localparam [2:0] RS_RESP = 3'b100;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function [2:0] aelr_decode;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `AELR_ADDR_ADV_CTRL: aelr_decode = `AELR_DEC_CTRL;
        `AELR_ADDR_HDR_LOG0: aelr_decode = `AELR_DEC_HDR;
        `AELR_ADDR_HDR_LOG1: aelr_decode = `AELR_DEC_HDR;
        `AELR_ADDR_HDR_LOG2: aelr_decode = `AELR_DEC_HDR;
        `AELR_ADDR_HDR_LOG3: aelr_decode = `AELR_DEC_HDR;
        `AELR_ADDR_SEC_STS:  aelr_decode = `AELR_DEC_SEC;
        default:             aelr_decode = `AELR_DEC_NONE;
      endcase
    end
  endfunction

  // Word 0 of the log sits at the lowest address; words wrap at bit 3
  function [1:0] aelr_hdr_idx;
    input [ADDR_W-1:0] addr;
    begin
      aelr_hdr_idx = addr[3:2] + 2'd1;
    end
  endfunction

  function [2:0] aelr_resp_ok;
    input [2:0] code;
    begin
      aelr_resp_ok = (code == `AELR_DEC_NONE) ? 3'd0 : 3'd1;
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [1:0]        wstate_reg;
  reg               aw_have_reg;
  reg               w_have_reg;
  reg  [ADDR_W-1:0] aw_addr_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;
  reg               awready_reg;
  reg               wready_reg;
  reg               bvalid_reg;
  reg  [1:0]        bresp_reg;

  reg  [2:0]        rstate_reg;
  reg  [2:0]        rd_code_reg;
  reg               arready_reg;
  reg               rvalid_reg;
  reg  [31:0]       rdata_reg;
  reg  [1:0]        rresp_reg;

  reg  [4:0]        fei_reg;
  reg  [4:0]        fei_next;
  reg               fei_armed_reg;
  reg               fei_armed_next;
  reg               hdr_lock_reg;
  reg               hdr_lock_next;
  reg  [15:0]       sec_sts_reg;
  reg  [15:0]       sec_sts_next;
  reg  [15:0]       sec_set;
  reg  [15:0]       sec_clr;
  reg  [31:0]       ctrl_word;
  reg  [31:0]       strb_mask;
  reg  [31:0]       rd_word;

  wire        aw_fire;
  wire        w_fire;
  wire        ar_fire;
  wire        wr_fire;
  wire [2:0]  wr_code;
  wire        hdr_capture;
  wire [31:0] hdr_rd_data;

  assign aw_fire     = s_axi_awvalid_i & awready_reg;
  assign w_fire      = s_axi_wvalid_i & wready_reg;
  assign ar_fire     = s_axi_arvalid_i & arready_reg;
  assign wr_fire     = wstate_reg[0] & aw_have_reg & w_have_reg;
  assign wr_code     = aelr_decode(aw_addr_reg);

  // ****************************************************************
  // First error pointer
  // ****************************************************************
  // A re-arm and a new error in the same cycle capture the new error
  always @* begin
    fei_next       = fei_reg;
    fei_armed_next = fei_armed_reg;
    if (!fei_armed_reg && unc_sts_clear_i[fei_reg]) begin
      fei_armed_next = 1'b1;
    end
    if (fei_armed_next && unc_err_valid_i) begin
      fei_next       = unc_err_index_i;
      fei_armed_next = 1'b0;
    end
  end

  // ****************************************************************
  // Header log lock
  // ****************************************************************
  // Set wins: a clear and a new error together leave a fresh capture
  assign hdr_capture = tlp_err_valid_i & (~hdr_lock_reg | hdr_sts_clear_i);

  always @* begin
    hdr_lock_next = hdr_lock_reg;
    if (hdr_sts_clear_i) begin
      hdr_lock_next = 1'b0;
    end
    if (hdr_capture) begin
      hdr_lock_next = 1'b1;
    end
  end

  // ****************************************************************
  // Secondary bus status
  // ****************************************************************
  always @* begin
    strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                 {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    sec_set = sec_err_event_i;
    sec_set[`AELR_SEC_IBF_BIT]  = internal_bridge_fault_i;
    sec_set[`AELR_SEC_SERR_BIT] = ~secondary_system_error_pin_n_i;
    sec_clr = 16'h0000;
    if (wr_fire && wr_code == `AELR_DEC_SEC) begin
      sec_clr = w_data_reg[15:0] & strb_mask[15:0];
    end
    // Events raised in the clearing cycle are kept
    sec_sts_next = ((sec_sts_reg & ~sec_clr) | sec_set)
                   & `AELR_SEC_STS_IMPL;
  end

  // ****************************************************************
  // Sticky state, cleared only by power-good reset
  // ****************************************************************
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fei_reg       <= `AELR_FEI_RST;
      fei_armed_reg <= 1'b1;
      hdr_lock_reg  <= 1'b0;
      sec_sts_reg   <= `AELR_SEC_STS_RST;
    end else if (ce_i) begin
      fei_reg       <= fei_next;
      fei_armed_reg <= fei_armed_next;
      hdr_lock_reg  <= hdr_lock_next;
      sec_sts_reg   <= sec_sts_next;
    end
  end

  // ****************************************************************
  // Header store
  // ****************************************************************
  aelr_hdr_mem #(
    .WORD_W (32),
    .WORDS  (4),
    .IDX_W  (2)
  ) u_hdr_mem (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .wr_en_i   (hdr_capture),
    .wr_data_i (tlp_hdr_i),
    .rd_en_i   (ar_fire),
    .rd_idx_i  (aelr_hdr_idx(s_axi_araddr_i)),
    .rd_data_o (hdr_rd_data)
  );

  // ****************************************************************
  // Read data mux
  // ****************************************************************
  always @* begin
    ctrl_word = `AELR_ADV_CTRL_RST;
    ctrl_word[`AELR_CRC_CHK_EN_BIT]  = 1'b0;
    ctrl_word[`AELR_CRC_CHK_CAP_BIT] = 1'b0;
    ctrl_word[`AELR_CRC_GEN_EN_BIT]  = 1'b0;
    ctrl_word[`AELR_CRC_GEN_CAP_BIT] = 1'b0;
    ctrl_word[`AELR_FEI_MSB:`AELR_FEI_LSB] = fei_reg;
    case (rd_code_reg)
      `AELR_DEC_CTRL: rd_word = ctrl_word;
      `AELR_DEC_HDR:  rd_word = hdr_rd_data;
      `AELR_DEC_SEC:  rd_word = {16'h0000, sec_sts_reg};
      default:        rd_word = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Writes to the control word and the log are accepted and dropped
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wstate_reg  <= WS_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AELR_RESP_OKAY;
    end else if (ce_i) begin
      if (link_rst_i) begin
        wstate_reg  <= WS_IDLE;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
        bvalid_reg  <= 1'b0;
      end else begin
        case (wstate_reg)
          WS_IDLE: begin
            if (aw_fire) begin
              aw_addr_reg <= s_axi_awaddr_i;
              aw_have_reg <= 1'b1;
              awready_reg <= 1'b0;
            end
            if (w_fire) begin
              w_data_reg <= s_axi_wdata_i;
              w_strb_reg <= s_axi_wstrb_i;
              w_have_reg <= 1'b1;
              wready_reg <= 1'b0;
            end
            if (wr_fire) begin
              bvalid_reg <= 1'b1;
              bresp_reg  <= (aelr_resp_ok(wr_code) == 3'd1) ?
                            `AELR_RESP_OKAY : `AELR_RESP_SLVERR;
              wstate_reg <= WS_RESP;
            end
          end
          WS_RESP: begin
            if (s_axi_bready_i) begin
              bvalid_reg  <= 1'b0;
              aw_have_reg <= 1'b0;
              w_have_reg  <= 1'b0;
              awready_reg <= 1'b1;
              wready_reg  <= 1'b1;
              wstate_reg  <= WS_IDLE;
            end
          end
          default: begin
            wstate_reg <= WS_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  // One extra cycle lets the header store present its registered word
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rstate_reg  <= RS_IDLE;
      rd_code_reg <= `AELR_DEC_NONE;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `AELR_RESP_OKAY;
    end else if (ce_i) begin
      if (link_rst_i) begin
        rstate_reg  <= RS_IDLE;
        arready_reg <= 1'b1;
        rvalid_reg  <= 1'b0;
      end else begin
        case (rstate_reg)
          RS_IDLE: begin
            if (ar_fire) begin
              rd_code_reg <= aelr_decode(s_axi_araddr_i);
              arready_reg <= 1'b0;
              rstate_reg  <= RS_DATA;
            end
          end
          RS_DATA: begin
            rdata_reg  <= rd_word;
            rresp_reg  <= (aelr_resp_ok(rd_code_reg) == 3'd1) ?
                          `AELR_RESP_OKAY : `AELR_RESP_SLVERR;
            rvalid_reg <= 1'b1;
            rstate_reg <= RS_RESP;
          end
          RS_RESP: begin
            if (s_axi_rready_i) begin
              rvalid_reg  <= 1'b0;
              arready_reg <= 1'b1;
              rstate_reg  <= RS_IDLE;
            end
          end
          default: begin
            rstate_reg <= RS_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready_o     = awready_reg;
  assign s_axi_wready_o      = wready_reg;
  assign s_axi_bvalid_o      = bvalid_reg;
  assign s_axi_bresp_o       = bresp_reg;
  assign s_axi_arready_o     = arready_reg;
  assign s_axi_rvalid_o      = rvalid_reg;
  assign s_axi_rdata_o       = rdata_reg;
  assign s_axi_rresp_o       = rresp_reg;
  assign first_error_index_o = fei_reg;
  assign hdr_log_locked_o    = hdr_lock_reg;

endmodule // aelr_top

// [aelr_monitor.sv]
// Concurrent checks on the ports of the advanced error log registers
`timescale 1ns/1ps
`include "aelr_defines.vh"

module aelr_monitor #(
  parameter ADDR_W = 12,
  parameter HDR_W  = 128
) (
  input wire              clock_i,
  input wire              rst_n_i,
  input wire              link_rst_i,
  input wire              unc_err_valid_i,
  input wire [4:0]        unc_err_index_i,
  input wire              tlp_err_valid_i,
  input wire              hdr_sts_clear_i,
  input wire              internal_bridge_fault_i,
  input wire              secondary_system_error_pin_n_i,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire              s_axi_arvalid_i,
  input wire              s_axi_arready_o,
  input wire [31:0]       s_axi_rdata_o,
  input wire              s_axi_rvalid_o,
  input wire              s_axi_rready_i,
  input wire [4:0]        first_error_index_o,
  input wire              hdr_log_locked_o
);
  // Address of the read in flight, so read data can be judged per register
  reg [ADDR_W-1:0] rd_addr_reg;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_addr_reg <= {ADDR_W{1'b0}};
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_addr_reg <= s_axi_araddr_i;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_ctrl_reads_zero : assert property (
    s_axi_rvalid_o && rd_addr_reg == `AELR_ADDR_ADV_CTRL
    |-> s_axi_rdata_o[31:5] == 27'h0000000)
    else $error("control word upper bits not zero");
  a_sts_reserved : assert property (
    s_axi_rvalid_o && rd_addr_reg == `AELR_ADDR_SEC_STS
    |-> s_axi_rdata_o[31:14] == 18'h00000 && !s_axi_rdata_o[4])
    else $error("reserved status bits not zero");
  a_index_source : assert property (
    first_error_index_o != $past(first_error_index_o)
    |-> $past(unc_err_valid_i)
        && first_error_index_o == $past(unc_err_index_i))
    else $error("pointer changed without a reported error");
  a_log_captures : assert property (
    tlp_err_valid_i |=> hdr_log_locked_o)
    else $error("header log not locked after an error");
  a_log_stays : assert property (
    hdr_log_locked_o && !hdr_sts_clear_i |=> hdr_log_locked_o)
    else $error("header log unlocked without a clear");
  a_log_unlocks : assert property (
    hdr_log_locked_o && hdr_sts_clear_i && !tlp_err_valid_i
    |=> !hdr_log_locked_o)
    else $error("header log stayed locked after a clear");
  a_fault_no_log : assert property (
    (internal_bridge_fault_i || !secondary_system_error_pin_n_i)
    && !tlp_err_valid_i && !hdr_log_locked_o |=> !hdr_log_locked_o)
    else $error("header captured on a queue or pin error");
  a_link_keeps : assert property (
    link_rst_i && !unc_err_valid_i |=> $stable(first_error_index_o))
    else $error("ordinary reset disturbed the pointer");
  a_read_answer : assert property (
    disable iff (!rst_n_i || link_rst_i)
    s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
    else $error("read answer late");
  a_read_holds : assert property (
    disable iff (!rst_n_i || link_rst_i)
    s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped before ready");
endmodule // aelr_monitor

bind aelr_top aelr_monitor #(.ADDR_W(ADDR_W), .HDR_W(HDR_W)) i_aelr_monitor (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .link_rst_i(link_rst_i),
  .unc_err_valid_i(unc_err_valid_i), .unc_err_index_i(unc_err_index_i),
  .tlp_err_valid_i(tlp_err_valid_i), .hdr_sts_clear_i(hdr_sts_clear_i),
  .internal_bridge_fault_i(internal_bridge_fault_i),
  .secondary_system_error_pin_n_i(secondary_system_error_pin_n_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .first_error_index_o(first_error_index_o),
  .hdr_log_locked_o(hdr_log_locked_o));

// [test_advanced_error_log_registers.sv]
// Self-checking bench for the advanced error log registers
`timescale 1ns/1ps
`include "aelr_defines.vh"

module test_advanced_error_log_registers;
  localparam [11:0] A_CTL = `AELR_ADDR_ADV_CTRL;
  localparam [11:0] A_HDR = `AELR_ADDR_HDR_LOG0;
  localparam [11:0] A_STS = `AELR_ADDR_SEC_STS;
  localparam [1:0]  OK    = `AELR_RESP_OKAY;
  localparam [1:0]  BAD   = `AELR_RESP_SLVERR;
  localparam [127:0] H1 = 128'h0123456789ABCDEFFEDCBA9876543210;
  localparam [127:0] H2 = 128'hA5A5A5A55A5A5A5AC3C3C3C33C3C3C3C;
  reg          clock_i = 1'b0;
  reg          rst_n_i = 1'b0;
  reg          link_rst = 1'b0, ue_v = 1'b0, te_v = 1'b0, hclr = 1'b0;
  reg          ibf = 1'b0, pin_n = 1'b1, ce = 1'b1;
  reg  [4:0]   ue_idx = 5'h00;
  reg  [31:0]  ue_clr = 32'h0;
  reg  [127:0] hdr = 128'h0;
  reg  [15:0]  evt = 16'h0000;
  reg  [11:0]  awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0]  wdata = 32'h0;
  reg  [3:0]   wstrb = 4'h0;
  reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg          arvalid = 1'b0, rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, locked;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [4:0]   fei;
  integer      n_fail = 0;
  integer      check_count = 0;

  always #12.5 clock_i = ~clock_i;

  aelr_top i_aelr_top (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .link_rst_i(link_rst), .unc_err_valid_i(ue_v), .unc_err_index_i(ue_idx),
    .unc_sts_clear_i(ue_clr), .tlp_err_valid_i(te_v), .tlp_hdr_i(hdr),
    .hdr_sts_clear_i(hclr), .internal_bridge_fault_i(ibf),
    .secondary_system_error_pin_n_i(pin_n), .sec_err_event_i(evt),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .first_error_index_o(fei), .hdr_log_locked_o(locked));

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask

  // Address and data are offered together; each is dropped once taken
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg     ad, wd;
    begin
      @(posedge clock_i);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      // Only the watchdog ends a wait for the response
      while (bvalid !== 1'b1) begin
        @(posedge clock_i);
        if (!ad && awready === 1'b1) begin
          ad = 1'b1;
          awvalid <= 1'b0;
        end
        if (!wd && wready === 1'b1) begin
          wd = 1'b1;
          wvalid <= 1'b0;
        end
      end
      chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
      bready <= 1'b0;
    end
  endtask

  task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (rvalid !== 1'b1) begin
        @(posedge clock_i);
        if (arready === 1'b1) begin
          arvalid <= 1'b0;
        end
      end
      chk(rdata, ed);
      chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
      rready <= 1'b0;
    end
  endtask

  task ue_err(input [4:0] i);
    begin
      @(posedge clock_i);
      ue_v <= 1'b1;
      ue_idx <= i;
      @(posedge clock_i);
      ue_v <= 1'b0;
    end
  endtask

  task ue_cl(input [4:0] i);
    begin
      @(posedge clock_i);
      ue_clr <= 32'h1 << i;
      @(posedge clock_i);
      ue_clr <= 32'h0;
    end
  endtask

  // Raises an error header, optionally with the unlock in the same cycle
  task tlp(input [127:0] h, input c);
    begin
      @(posedge clock_i);
      te_v <= 1'b1;
      hdr <= h;
      hclr <= c;
      @(posedge clock_i);
      te_v <= 1'b0;
      hclr <= 1'b0;
    end
  endtask

  task rd_hdr(input [127:0] h);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rd(A_HDR + 12'h004 * i[11:0], h[32*i +: 32], OK);
      end
    end
  endtask

  task t_reset_vals;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        rd(A_CTL + 12'h004 * i[11:0], 32'h0, OK);
      end
    end
  endtask

  task t_ctrl_ro;
    begin
      wr(A_CTL, 32'hFFFFFFFF, 4'hF, OK);
      rd(A_CTL, 32'h0, OK);
      wr(A_HDR, 32'hFFFFFFFF, 4'hF, OK);
      rd(A_HDR, 32'h0, OK);
      rd(12'h200, 32'h0, BAD);
      rd(12'h119, 32'h0, BAD);
      wr(12'h200, 32'hFFFFFFFF, 4'hF, BAD);
    end
  endtask

  task t_pointer;
    begin
      ue_err(5'h05);
      rd(A_CTL, 32'h5, OK);
      ue_err(5'h09);
      ue_cl(5'h09);
      ue_err(5'h03);
      rd(A_CTL, 32'h5, OK);
      ue_cl(5'h05);
      chk({27'h0, fei}, 32'h5);
      ue_err(5'h1F);
      rd(A_CTL, 32'h1F, OK);
    end
  endtask

  task t_header;
    begin
      tlp(H1, 1'b0);
      rd_hdr(H1);
      tlp(H2, 1'b0);
      rd_hdr(H1);
      @(posedge clock_i);
      hclr <= 1'b1;
      @(posedge clock_i);
      hclr <= 1'b0;
      @(posedge clock_i);
      chk({31'h0, locked}, 32'h0);
      tlp(H2, 1'b0);
      rd_hdr(H2);
      tlp(H1, 1'b1);
      rd_hdr(H1);
    end
  endtask

  task t_status;
    begin
      // Clock enable low: an event in that cycle must not be taken
      @(posedge clock_i);
      ce <= 1'b0;
      evt <= 16'hFFFF;
      @(posedge clock_i);
      ce <= 1'b1;
      evt <= 16'h0000;
      rd(A_STS, 32'h0, OK);
      @(posedge clock_i);
      evt <= 16'hFFFF;
      @(posedge clock_i);
      evt <= 16'h0000;
      rd(A_STS, 32'h0FEF, OK);
      @(posedge clock_i);
      ibf <= 1'b1;
      @(posedge clock_i);
      ibf <= 1'b0;
      rd(A_STS, 32'h2FEF, OK);
      @(posedge clock_i);
      pin_n <= 1'b0;
      @(posedge clock_i);
      pin_n <= 1'b1;
      rd(A_STS, 32'h3FEF, OK);
      wr(A_STS, 32'h2001, 4'hF, OK);
      rd(A_STS, 32'h1FEE, OK);
      wr(A_STS, 32'h0, 4'hF, OK);
      rd(A_STS, 32'h1FEE, OK);
      wr(A_STS, 32'hFFFF, 4'h2, OK);
      rd(A_STS, 32'h00EE, OK);
      wr(A_STS, 32'hFFFF, 4'hF, OK);
      rd(A_STS, 32'h0, OK);
    end
  endtask

  task t_resets;
    begin
      @(posedge clock_i);
      link_rst <= 1'b1;
      @(posedge clock_i);
      link_rst <= 1'b0;
      rd(A_CTL, 32'h1F, OK);
      rd(A_HDR, H1[31:0], OK);
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(A_CTL, 32'h0, OK);
      rd(A_HDR, 32'h0, OK);
      chk({31'h0, locked}, 32'h0);
    end
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset_vals;
    t_ctrl_ro;
    t_pointer;
    // Status faults run while the log is unlocked, so no capture shows
    t_status;
    t_header;
    t_resets;
    report_and_stop;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule // test_advanced_error_log_registers
